/* core/flash_section_lock_enforcer.sv */
// Purpose: Keeps the protection byte and grants or blocks accesses
// Assumes: Single clock pclk; pins arrive unsynchronised
// Notes:   Fields only tighten; chip erase or presetn restores the erased value
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "lock_defines.svh"

// Overview of operation
// - Boot field only moves toward stricter
// - Boot field erased only by chip erase; presetn here also reloads it to ones
// - Boot 11 free, 10 blocks boot stores
// - Boot 01 blocks app loads; 00 both
// - Boot read lock masks interrupts in boot if vectors in app
// - Application field only moves toward stricter
// - Application field erased only by chip erase; presetn here also reloads it to ones
// - App 10/00 block stores; 11 free
// - App 01/00 block loads from boot
// - App read lock masks interrupts in app if vectors in boot
// - Table field tightens only, erase clears
// - Table 10 stores, 01 loads, 00 both
// - External lock written only by programmer
// - External lock erased only by chip erase; presetn here also reloads it to ones
// - Any zero lock bit blocks test/debug
// - External lock never restricts CPU accesses
// - External 10 blocks memory and fuse writes
// - External 00 blocks all memory, lock, fuse
// - External 11 applies no external locking
module flash_section_lock_enforcer (
    input  wire logic              pclk,          // Bus clock
    input  wire logic              presetn,       // Async reset, low
    input  wire logic              psel,          // APB select
    input  wire logic              penable,       // APB access phase
    input  wire logic              pwrite,        // APB direction
    input  wire logic [11:0]       paddr,         // APB byte address
    input  wire logic [31:0]       pwdata,        // APB write data
    output logic                   pready,        // APB ready
    output logic      [31:0]       prdata,        // APB read data
    output logic                   pslverr,       // APB error
    input  wire lock_pkg::cpu_req_t cpu_req,      // CPU access query
    output logic                   cpu_grant,     // CPU access allowed
    input  wire logic              cpu_in_boot,   // CPU executes in boot
    output logic                   irq_disable,   // Mask CPU interrupts
    input  wire lock_pkg::ext_req_t ext_req,      // Programmer query
    output logic                   ext_grant,     // Programmer allowed
    input  wire logic              ext_lock_we,   // Programmer lock write
    input  wire logic [7:0]        ext_lock_data, // Programmer lock data
    input  wire logic              chip_erase,    // Chip erase strobe
    input  wire logic              dbg_req,       // Test or debug access
    output logic                   dbg_grant      // Test/debug allowed
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0] erase_sync;       // Chip erase, two stages
    logic [1:0] ext_we_sync;      // Programmer write strobe
    logic       erase_seen;       // Erase level of last cycle
    logic       ext_we_seen;      // Write level of last cycle
    logic       erase_pulse;      // Erase rising edge
    logic       ext_we_pulse;     // Programmer write rising edge

    // Two flip-flops before anything reads the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_sync  <= 2'h0;
            ext_we_sync <= 2'h0;
        end else begin
            erase_sync  <= {erase_sync[0], chip_erase};
            ext_we_sync <= {ext_we_sync[0], ext_lock_we};
        end
    end

    // Edge detect on the second stage only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_seen  <= 1'b0;
            ext_we_seen <= 1'b0;
        end else begin
            erase_seen  <= erase_sync[1];
            ext_we_seen <= ext_we_sync[1];
        end
    end

    assign erase_pulse  = erase_sync[1] & ~erase_seen;
    assign ext_we_pulse = ext_we_sync[1] & ~ext_we_seen;

    // Data is held steady by the programmer around its strobe
    logic [7:0] ext_data_s1;      // First stage, feeds stage two only
    logic [7:0] ext_data_s2;      // Synchronised programmer data

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_data_s1 <= 8'hff;
            ext_data_s2 <= 8'hff;
        end else begin
            ext_data_s1 <= ext_lock_data;
            ext_data_s2 <= ext_data_s1;
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    lock_pkg::bus_state_t bus_state;  // Answer sequencer
    logic       vec_in_boot;          // Interrupt vectors in boot
    logic       setup;                // Setup phase seen
    logic       sw_lock_write;        // Software protection write
    logic       ctrl_write;           // Control register write
    logic       mapped;               // Address decodes

    assign setup = psel & ~penable;

    // One wait state: answer in the cycle after the first access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state <= lock_pkg::bus_idle;
        end else begin
            case (bus_state)
                lock_pkg::bus_idle: begin
                    if (psel && penable) begin
                        bus_state <= lock_pkg::bus_done;
                    end
                end
                lock_pkg::bus_done: begin
                    bus_state <= lock_pkg::bus_idle;
                end
                default: begin
                    bus_state <= lock_pkg::bus_idle;
                end
            endcase
        end
    end

    assign pready = (bus_state == lock_pkg::bus_done);

    // Decode of the three words
    always_comb begin
        case (paddr)
            `PROT_SETTINGS_OFS,
            `ACCESS_CTRL_OFS,
            `ACCESS_STATUS_OFS: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
    end

    assign pslverr = pready & ~mapped;
    assign sw_lock_write = pready & psel & penable & pwrite
                           & (paddr == `PROT_SETTINGS_OFS);
    assign ctrl_write = pready & psel & penable & pwrite
                        & (paddr == `ACCESS_CTRL_OFS);

    // ************************************************************
    // Protection byte
    // ************************************************************
    logic [7:0] prot;             // memory_protection_settings
    logic [7:0] next_prot;        // Value after this cycle
    logic [7:0] sw_mask;          // Bits software may lower
    logic       ext_grant_locks_write; // Programmer may write lock byte

    // Software never touches the external lock field
    assign sw_mask = 8'hfc;

    always_comb begin
        next_prot = prot;
        if (sw_lock_write) begin
            // AND keeps tightening only for the three section fields
            next_prot = next_prot & (pwdata[7:0] | ~sw_mask);
        end
        if (ext_we_pulse && ext_grant_locks_write) begin
            // Programmer may tighten every field, lock bits included
            next_prot = next_prot & ext_data_s2;
        end
        if (erase_pulse) begin
            // Erase wins over any write in the same cycle
            next_prot = `PROT_RESET_VALUE;
        end
    end

    // Byte register; only erase or reset restores ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot <= `PROT_RESET_VALUE;
        end else begin
            prot <= next_prot;
        end
    end

    // Interrupt vector placement, set by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_in_boot <= 1'b0;
        end else if (ctrl_write) begin
            vec_in_boot <= pwdata[`CTRL_VEC_IN_BOOT];
        end
    end

    // ************************************************************
    // Field views
    // ************************************************************
    logic [1:0] boot_section_protection;
    logic [1:0] application_section_protection;
    logic [1:0] application_table_protection;
    logic [1:0] external_programming_lock;

    assign boot_section_protection =
        prot[`BOOT_FIELD_HI:`BOOT_FIELD_LO];
    assign application_section_protection =
        prot[`APP_FIELD_HI:`APP_FIELD_LO];
    assign application_table_protection =
        prot[`TABLE_FIELD_HI:`TABLE_FIELD_LO];
    assign external_programming_lock =
        prot[`EXT_FIELD_HI:`EXT_FIELD_LO];

    // Bit 0 of a field clear means writes locked, bit 1 clear reads
    logic boot_wr_lock;
    logic boot_rd_lock;
    logic app_wr_lock;
    logic app_rd_lock;
    logic tbl_wr_lock;
    logic tbl_rd_lock;

    assign boot_wr_lock = ~boot_section_protection[0];
    assign boot_rd_lock = ~boot_section_protection[1];
    assign app_wr_lock  = ~application_section_protection[0];
    assign app_rd_lock  = ~application_section_protection[1];
    assign tbl_wr_lock  = ~application_table_protection[0];
    assign tbl_rd_lock  = ~application_table_protection[1];

    // ************************************************************
    // CPU access decision
    // ************************************************************
    // External lock field is not consulted here
    always_comb begin
        cpu_grant = 1'b1;
        if (cpu_req.valid) begin
            case (cpu_req.target)
                lock_pkg::sec_boot: begin
                    if (cpu_req.store) begin
                        cpu_grant = ~boot_wr_lock;
                    end else if (!cpu_req.from_boot) begin
                        cpu_grant = ~boot_rd_lock;
                    end
                end
                lock_pkg::sec_application: begin
                    if (cpu_req.store) begin
                        cpu_grant = ~app_wr_lock;
                    end else if (cpu_req.from_boot) begin
                        cpu_grant = ~app_rd_lock;
                    end
                end
                lock_pkg::sec_app_table: begin
                    if (cpu_req.store) begin
                        cpu_grant = ~tbl_wr_lock;
                    end else if (cpu_req.from_boot) begin
                        cpu_grant = ~tbl_rd_lock;
                    end
                end
                default: begin
                    cpu_grant = 1'b1;
                end
            endcase
        end
    end

    // Interrupt masking while running in a read-locked section
    assign irq_disable =
        (boot_rd_lock & ~vec_in_boot & cpu_in_boot)
        | (app_rd_lock & vec_in_boot & ~cpu_in_boot);

    // ************************************************************
    // External interface decision
    // ************************************************************
    logic ext_any_lock;           // Any lock bit cleared
    logic ext_write_locked;       // Write lock level or stricter
    logic ext_rw_locked;          // Both bits cleared

    assign ext_any_lock     = ~&external_programming_lock;
    assign ext_write_locked = ~external_programming_lock[0];
    assign ext_rw_locked    = ~|external_programming_lock;

    // Tightening stays possible unless fully locked
    assign ext_grant_locks_write = ~ext_rw_locked;

    always_comb begin
        ext_grant = 1'b1;
        if (ext_req.valid) begin
            case (ext_req.target)
                lock_pkg::ext_memory: begin
                    ext_grant = ext_req.write ? ~ext_write_locked
                                              : ~ext_rw_locked;
                end
                lock_pkg::ext_fuses: begin
                    ext_grant = ext_req.write ? ~ext_write_locked
                                              : ~ext_rw_locked;
                end
                lock_pkg::ext_locks: begin
                    ext_grant = ~ext_rw_locked;
                end
                default: begin
                    ext_grant = 1'b1;
                end
            endcase
        end
    end

    // Test and debug paths shut by any cleared lock bit
    assign dbg_grant = dbg_req & ~ext_any_lock;

    // ************************************************************
    // Read data
    // ************************************************************
    // Registered so the data stands with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && penable && !pwrite && !pready) begin
            case (paddr)
                `PROT_SETTINGS_OFS: prdata <= {24'h0, prot};
                `ACCESS_CTRL_OFS:   prdata <= {31'h0, vec_in_boot};
                `ACCESS_STATUS_OFS: prdata <= {29'h0, irq_disable,
                                               ext_any_lock, ext_rw_locked};
                default:            prdata <= 32'h0;
            endcase
        end
    end

    // Unused setup decode kept readable for future decode stage
    logic unused_setup;
    assign unused_setup = setup;

endmodule
`default_nettype wire

/* core/lock_defines.svh */
// Purpose: Offsets, field positions and reset values of the lock block
// Assumes: APB slave, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef LOCK_DEFINES_SVH
`define LOCK_DEFINES_SVH

// Register byte offsets
`define PROT_SETTINGS_OFS   12'h000
`define ACCESS_CTRL_OFS     12'h004
`define ACCESS_STATUS_OFS   12'h008

// Field positions inside the protection byte
`define BOOT_FIELD_HI       7
`define BOOT_FIELD_LO       6
`define APP_FIELD_HI        5
`define APP_FIELD_LO        4
`define TABLE_FIELD_HI      3
`define TABLE_FIELD_LO      2
`define EXT_FIELD_HI        1
`define EXT_FIELD_LO        0

// Erased (unprotected) value of the whole byte
`define PROT_RESET_VALUE    8'hff

// Bits of the access control register
`define CTRL_VEC_IN_BOOT    0

`endif

/* core/lock_pkg.sv */
// Purpose: Types shared by the lock block
// Assumes: Field encodings of the protection byte
// Notes:   Constants live in lock_defines.svh
package lock_pkg;

    // Two-bit protection level; lower is stricter
    typedef enum logic [1:0] {
        read_write_protect_setting = 2'h0,
        read_protect_setting       = 2'h1,
        write_protect_setting      = 2'h2,
        unprotected_setting        = 2'h3
    } prot_level_t;

    // CPU program-memory request
    typedef struct packed {
        logic        valid;       // Request present
        logic        store;       // 1 store, 0 load
        logic        from_boot;   // Executing from boot section
        logic [1:0]  target;      // Target section code
    } cpu_req_t;

    // External programming interface request
    typedef struct packed {
        logic        valid;       // Request present
        logic        write;       // 1 write, 0 read or verify
        logic [1:0]  target;      // Target space code
    } ext_req_t;

    // CPU target section codes
    typedef enum logic [1:0] {
        sec_application = 2'h0,
        sec_app_table   = 2'h1,
        sec_boot        = 2'h2,
        sec_none        = 2'h3
    } section_t;

    // External target codes
    typedef enum logic [1:0] {
        ext_memory = 2'h0,   // Flash or EEPROM
        ext_fuses  = 2'h1,
        ext_locks  = 2'h2,
        ext_other  = 2'h3
    } ext_target_t;

    // APB slave states
    typedef enum logic [0:0] {
        bus_idle,
        bus_done
    } bus_state_t;

endpackage

/* verification/lock_asserts.sv */
// Purpose: Port-level checks of the lock block
// Assumes: One clock, async active-low reset
// Notes:   Bound to the block after the module
`timescale 1ns/1ns
`default_nettype none
`include "lock_defines.svh"
module lock_asserts (
    input wire logic               pclk,       // Bus clock
    input wire logic               presetn,    // Async reset, low
    input wire logic               psel,       // APB select
    input wire logic               penable,    // APB access phase
    input wire logic               pwrite,     // APB direction
    input wire logic [11:0]        paddr,      // APB address
    input wire logic               pready,     // APB ready
    input wire logic [31:0]        prdata,     // APB read data
    input wire logic               pslverr,    // APB error
    input wire lock_pkg::ext_req_t ext_req,    // Programmer query
    input wire logic               ext_grant,  // Programmer allowed
    input wire logic               chip_erase, // Erase pin
    input wire logic               dbg_req,    // Debug query
    input wire logic               dbg_grant   // Debug allowed
);
    // ****************************************
    // Helper state
    // ****************************************
    logic       rd0;       // Finished read of protection byte
    logic       mapped;    // Address hits a register
    logic       have_last; // Earlier byte value known
    logic       erased;    // Erase seen since that read
    logic [7:0] last;      // Byte at the earlier read
    assign rd0 = psel && penable && pready && !pwrite && paddr == 12'h000;
    assign mapped = paddr inside {`PROT_SETTINGS_OFS, `ACCESS_CTRL_OFS,
                                  `ACCESS_STATUS_OFS};
    // An erase exempts the next read, since bits may legally rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            have_last <= 1'b0;
            erased    <= 1'b0;
            last      <= 8'hff;
        end else if (rd0) begin
            have_last <= 1'b1;
            erased    <= chip_erase;
            last      <= prdata[7:0];
        end else if (chip_erase) begin
            erased <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_after: assert property (
        psel && penable && !pready |=> pready)
        else $error("No answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready held longer than one cycle");
    a_err_unmapped: assert property (
        psel && penable && pready |-> pslverr == !mapped)
        else $error("Error flag does not match address map");
    a_unmapped_zero: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("Unmapped read not zero");
    a_tighten_only: assert property (
        rd0 && have_last && !erased |-> (prdata[7:0] & ~last) == 8'h00)
        else $error("Protection bit relaxed without erase");
    a_dbg_locked: assert property (
        rd0 && dbg_req && prdata[1:0] != 2'h3 |-> !dbg_grant)
        else $error("Debug granted with a lock bit clear");
    a_dbg_needs_req: assert property (dbg_grant |-> dbg_req)
        else $error("Debug grant without request");
    a_ext_idle: assert property (!ext_req.valid |-> ext_grant)
        else $error("Idle programmer query refused");
endmodule
bind flash_section_lock_enforcer lock_asserts u_lock_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ext_req(ext_req), .ext_grant(ext_grant),
    .chip_erase(chip_erase), .dbg_req(dbg_req), .dbg_grant(dbg_grant));
`default_nettype wire

/* verification/prog_model.sv */
// Purpose: External programmer driving lock and erase pins
// Assumes: Pins are sampled through a two-stage synchroniser
// Notes:   Data held four cycles either side of the strobe
`timescale 1ns/1ns
`default_nettype none
module prog_model (
    input  wire logic pclk,          // Bus clock
    output logic      ext_lock_we,   // Lock write strobe
    output logic [7:0] ext_lock_data, // Lock data
    output logic      chip_erase     // Erase strobe
);
    // ****************************************
    // Pin sequences
    // ****************************************
    initial begin
        ext_lock_we   = 1'b0;
        ext_lock_data = 8'h00;
        chip_erase    = 1'b0;
    end
    // Caller sets the other fields first
    task automatic lock_write(input logic [7:0] d);
        @(posedge pclk);
        ext_lock_data <= d;
        repeat (4) @(posedge pclk);
        ext_lock_we <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_lock_we <= 1'b0;
        repeat (4) @(posedge pclk);
        ext_lock_data <= ~d; // Released: no stale value left
        repeat (2) @(posedge pclk);
    endtask
    // Long enough for the synchroniser to pass it on
    task automatic erase();
        @(posedge pclk);
        chip_erase <= 1'b1;
        repeat (3) @(posedge pclk);
        chip_erase <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* verification/tb_flash_section_lock_enforcer.sv */
// Purpose: Self-checking bench of the lock block
// Assumes: APB answers after one wait state
// Notes:   Reference model held in plain variables
`timescale 1ns/1ns
`default_nettype none
`include "lock_defines.svh"
module tb_flash_section_lock_enforcer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic cpu_grant, cpu_in_boot, irq_disable, ext_grant, ext_lock_we;
    logic chip_erase, dbg_req, dbg_grant;
    logic [11:0] paddr;       // Bus address
    logic [31:0] pwdata, prdata, rd, v;
    logic [7:0]  ext_lock_data;
    lock_pkg::cpu_req_t cpu_req;
    lock_pkg::ext_req_t ext_req;
    int          error_cnt, tests_run, seed, i, lvl;
    logic [7:0]  model_prot;  // Expected protection byte
    logic        model_vec;   // Expected vector placement
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    flash_section_lock_enforcer dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu_req(cpu_req), .cpu_grant(cpu_grant),
        .cpu_in_boot(cpu_in_boot), .irq_disable(irq_disable),
        .ext_req(ext_req), .ext_grant(ext_grant),
        .ext_lock_we(ext_lock_we), .ext_lock_data(ext_lock_data),
        .chip_erase(chip_erase), .dbg_req(dbg_req), .dbg_grant(dbg_grant));
    prog_model prog (.pclk(pclk), .ext_lock_we(ext_lock_we),
        .ext_lock_data(ext_lock_data), .chip_erase(chip_erase));
    // ****************************************
    // Model, compares and bus
    // ****************************************
    function automatic logic exp_cpu(input logic [4:0] r);
        logic [1:0] lv;
        lv = (r[1:0] == 2'h0) ? model_prot[5:4] :
             (r[1:0] == 2'h1) ? model_prot[3:2] : model_prot[7:6];
        if (!r[4] || r[1:0] == 2'h3) return 1'b1;
        if (r[3]) return lv[0];
        if (r[1:0] == 2'h2) return lv[1] || r[2];
        return lv[1] || !r[2];
    endfunction
    function automatic logic exp_ext(input logic [3:0] r);
        logic [1:0] lb;
        lb = model_prot[1:0];
        if (!r[3] || r[1:0] == 2'h3 || lb == 2'h3) return 1'b1;
        if (r[2] && r[1:0] != 2'h2) return lb[0];
        if (r[1:0] == 2'h0) return lb[1];
        return lb != 2'h0;
    endfunction
    function automatic logic exp_irq(input logic b);
        return model_vec ? (!b && !model_prot[5])
                         : (b && !model_prot[7]);
    endfunction
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_val({31'h0, got}, {31'h0, exp});
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One transfer; a missing answer ends the run
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            check_bit(pready, 1'b1);
            end_sim();
        end
    endtask
    // Every query combination, judged mid-cycle
    task automatic check_all();
        for (i = 0; i < 64; i++) begin
            @(posedge pclk);
            cpu_req <= lock_pkg::cpu_req_t'(i[4:0]);
            ext_req <= lock_pkg::ext_req_t'(i[3:0]);
            cpu_in_boot <= i[5];
            dbg_req <= i[0];
            @(negedge pclk);
            check_bit(cpu_grant, exp_cpu(i[4:0]));
            check_bit(ext_grant, exp_ext(i[3:0]));
            check_bit(dbg_grant, i[0] & (&model_prot[1:0]));
            check_bit(irq_disable, exp_irq(i[5]));
        end
    endtask
    task automatic check_regs();
        apb(`PROT_SETTINGS_OFS, 1'b0, 32'h0);
        check_val(rd, {24'h0, model_prot});
        apb(`ACCESS_CTRL_OFS, 1'b0, 32'h0);
        check_val(rd, {31'h0, model_vec});
        apb(`ACCESS_STATUS_OFS, 1'b0, 32'h0);
        check_val(rd, {29'h0, exp_irq(cpu_in_boot),
            model_prot[1:0] != 2'h3, model_prot[1:0] == 2'h0});
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, cpu_in_boot, dbg_req} = 6'h00;
        {paddr, pwdata, cpu_req, ext_req} = '0;
        {error_cnt, tests_run, model_vec} = '0;
        seed = 32'hd976;
        model_prot = 8'hff;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check_regs();
        apb(12'h00c, 1'b1, 32'hffffffff);
        apb(12'h00c, 1'b0, 32'h0);
        check_val(rd, 32'h0);
        check_bit(err, 1'b1);
        $display("test reset_and_map finished");
        // Each level in all three fields, then a relax attempt
        for (lvl = 0; lvl < 10; lvl++) begin
            prog.erase();
            model_prot = 8'hff;
            v = {24'h0, lvl[1:0], lvl[1:0], lvl[1:0], 2'h0};
            if (lvl > 3) v = $random(seed);
            apb(`PROT_SETTINGS_OFS, 1'b1, v);
            model_prot &= v[7:0] | 8'h03;
            v = (lvl > 3) ? $random(seed) : lvl;
            apb(`ACCESS_CTRL_OFS, 1'b1, {31'h0, v[0]});
            model_vec = v[0];
            check_all();
            apb(`PROT_SETTINGS_OFS, 1'b1, 32'hff);
            check_regs();
        end
        $display("test software_levels finished");
        apb(`PROT_SETTINGS_OFS, 1'b1, 32'h6f);
        model_prot &= 8'h6f;
        for (lvl = 0; lvl < 3; lvl++) begin
            v = (lvl == 0) ? 32'hfe : (lvl == 1) ? 32'hfc : 32'hff;
            prog.lock_write(v[7:0]);
            model_prot &= v[7:0];
            check_all();
            check_regs();
        end
        prog.erase();
        model_prot = 8'hff;
        check_regs();
        $display("test external_lock finished");
        end_sim();
    end
endmodule
`default_nettype wire
